// ### rtl/uxp_io_regulator_ctrl.sv
// I/O and regulator control register with its APB slave and output logic.
//
// What this block does
// - Register reads at three addresses; writes, sets, clears at first, second, third.
// - Swap bit exchanges plus and minus line roles for the transceiver.
// - Swap exchanges serial lines in serial mode; speaker routing untouched.
// - Serial field picks regulator level in serial mode; reset value 3.0V.
// - Entering serial mode, level moves to serial field once transmit drive asserts.
// - Audio mode holds regulator at 3.3V regardless of the serial field.
// - Bits 4 and 5 enable pull-ups; both forced on in serial mode.
// - Bus field sets regulator level outside audio mode, except in serial mode once transmit drive asserts.
`timescale 1ns/1ps
module uxp_io_regulator_ctrl #(
	parameter int unsigned ADDR_W = 10
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Mode from the transceiver core
	input wire logic [1:0] phy_mode,
	input wire logic transmit_drive_enable,
	// Transceiver side
	input wire logic xcvr_dp_out,
	input wire logic xcvr_dm_out,
	input wire logic xcvr_dp_oe,
	input wire logic xcvr_dm_oe,
	output logic xcvr_dp_in,
	output logic xcvr_dm_in,
	// Serial side
	input wire logic uart_tx,
	output logic uart_rx,
	// Data pins
	input wire logic dp_i,
	input wire logic dm_i,
	output logic dp_o,
	output logic dp_oe,
	output logic dm_o,
	output logic dm_oe,
	// Analogue controls
	output logic [1:0] regulated_supply_level,
	output logic charger_pullup_plus_line,
	output logic charger_pullup_minus_line,
	output logic audio_path_en
);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (ADDR_W < uxp_pkg::ADDR_W_MIN || ADDR_W > 32)
	begin : g_bad_addr_w
		$error("ADDR_W must lie between 10 and 32.");
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic pready_r;
	wire [9:0] addr_lo = paddr[9:0];
	wire addr_hi_zero = (paddr >> 10) == '0;
	wire hit_write = addr_hi_zero && (addr_lo == uxp_pkg::ADDR_WRITE);
	wire hit_set = addr_hi_zero && (addr_lo == uxp_pkg::ADDR_SET);
	wire hit_clear = addr_hi_zero && (addr_lo == uxp_pkg::ADDR_CLEAR);
	wire hit_any = hit_write || hit_set || hit_clear;
	wire setup_ph = psel && !penable;
	wire wr_take = psel && penable && pready_r && pwrite && pstrb[0];
	wire [7:0] wdata_m = pwdata[7:0] & uxp_pkg::CTRL_WMASK;

	// ------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------
	// set and clear
	assign ctrl_nxt = !wr_take ? ctrl_r :
		hit_write ? wdata_m :
		hit_set ? (ctrl_r | wdata_m) :
		hit_clear ? (ctrl_r & ~wdata_m) : ctrl_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_r <= uxp_pkg::CTRL_RESET;
		else
			ctrl_r <= ctrl_nxt;
	end

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	// The slave answers in the first access cycle, with no extra wait.
	wire pready_nxt = setup_ph;
	wire [31:0] rdata_nxt = hit_any ? {24'h000000, ctrl_r} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready_r <= pready_nxt;
			prdata <= setup_ph ? rdata_nxt : 32'h00000000;
			pslverr <= setup_ph && !hit_any;
		end
	end
	assign pready = pready_r;

	// ------------------------------------------------------------
	// Mode and regulator level
	// ------------------------------------------------------------
	logic ser_armed_r;
	wire mode_serial = phy_mode == uxp_pkg::MODE_SERIAL;
	wire mode_audio = phy_mode == uxp_pkg::MODE_AUDIO;
	wire [1:0] ser_lvl = ctrl_r[uxp_pkg::LSB_SER_LVL +: 2];
	wire [1:0] bus_lvl = ctrl_r[uxp_pkg::LSB_BUS_LVL +: 2];
	wire ser_armed_nxt = mode_serial && (ser_armed_r || transmit_drive_enable);
	wire [1:0] lvl_nxt = mode_audio ? uxp_pkg::LVL_3V3 :
		ser_armed_nxt ? ser_lvl :
		bus_lvl;
	wire pu_plus_nxt = ctrl_r[uxp_pkg::BIT_PU_PLUS] || mode_serial;
	wire pu_minus_nxt = ctrl_r[uxp_pkg::BIT_PU_MINUS] || mode_serial;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ser_armed_r <= 1'b0;
			regulated_supply_level <= uxp_pkg::LVL_3V3;
			charger_pullup_plus_line <= 1'b0;
			charger_pullup_minus_line <= 1'b0;
			audio_path_en <= 1'b0;
		end
		else
		begin
			ser_armed_r <= ser_armed_nxt;
			regulated_supply_level <= lvl_nxt;
			charger_pullup_plus_line <= pu_plus_nxt;
			charger_pullup_minus_line <= pu_minus_nxt;
			audio_path_en <= mode_audio;
		end
	end

	// ------------------------------------------------------------
	// Line routing
	// ------------------------------------------------------------
	// swap lines
	wire swap_en = ctrl_r[uxp_pkg::BIT_SWAP];

	uxp_line_route u_route (
		.pclk(pclk),
		.presetn(presetn),
		.swap_en(swap_en),
		.serial_mode(mode_serial),
		.audio_mode(mode_audio),
		.xcvr_dp_out(xcvr_dp_out),
		.xcvr_dm_out(xcvr_dm_out),
		.xcvr_dp_oe(xcvr_dp_oe),
		.xcvr_dm_oe(xcvr_dm_oe),
		.xcvr_dp_in(xcvr_dp_in),
		.xcvr_dm_in(xcvr_dm_in),
		.uart_tx(uart_tx),
		.uart_rx(uart_rx),
		.dp_i(dp_i),
		.dm_i(dm_i),
		.dp_o(dp_o),
		.dp_oe(dp_oe),
		.dm_o(dm_o),
		.dm_oe(dm_oe)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_read_alias;
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && hit_any) |=> (prdata == {24'h000000, $past(ctrl_r)})
			&& pready && !pslverr;
	endproperty
	a_read_alias: assert property (p_read_alias)
		else $error("Read of an alias did not return the register.");

	property p_write_direct;
		@(posedge pclk) disable iff (!presetn)
		(wr_take && hit_write) |=> (ctrl_r == ($past(pwdata[7:0]) & 8'hFE));
	endproperty
	a_write_direct: assert property (p_write_direct)
		else $error("Direct write did not load the register.");

	property p_set_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr_take && (hit_set || hit_clear)) |=> (ctrl_r == ($past(hit_set)
			? ($past(ctrl_r) | ($past(pwdata[7:0]) & 8'hFE))
			: ($past(ctrl_r) & ~($past(pwdata[7:0]) & 8'hFE))));
	endproperty
	a_set_clear: assert property (p_set_clear)
		else $error("Set or clear alias changed the wrong bits.");

	property p_swap_bus;
		@(posedge pclk) disable iff (!presetn)
		(phy_mode == uxp_pkg::MODE_BUS && swap_en) |=>
			(dm_o == $past(xcvr_dp_out)) && (dp_o == $past(xcvr_dm_out))
			&& (dm_oe == $past(xcvr_dp_oe));
	endproperty
	a_swap_bus: assert property (p_swap_bus)
		else $error("Swapped lines do not carry the exchanged roles.");

	property p_swap_serial;
		@(posedge pclk) disable iff (!presetn)
		mode_serial |=> (dp_oe == $past(swap_en)) && (dm_oe == !$past(swap_en));
	endproperty
	a_swap_serial: assert property (p_swap_serial)
		else $error("Serial transmit sits on the wrong line.");

	property p_audio_quiet;
		@(posedge pclk) disable iff (!presetn)
		mode_audio [*2] |-> !dp_oe && !dm_oe && audio_path_en;
	endproperty
	a_audio_quiet: assert property (p_audio_quiet)
		else $error("Data lines driven in audio mode.");

	property p_serial_level;
		@(posedge pclk) disable iff (!presetn)
		(mode_serial && transmit_drive_enable) ##1 mode_serial |=>
			regulated_supply_level == $past(ser_lvl);
	endproperty
	a_serial_level: assert property (p_serial_level)
		else $error("Serial level not applied after transmit drive.");

	property p_serial_wait;
		@(posedge pclk) disable iff (!presetn)
		(!mode_serial ##1 (mode_serial && !transmit_drive_enable)) |=>
			regulated_supply_level == $past(bus_lvl);
	endproperty
	a_serial_wait: assert property (p_serial_wait)
		else $error("Level changed before transmit drive asserted.");

	property p_audio_level;
		@(posedge pclk) disable iff (!presetn)
		mode_audio |=> regulated_supply_level == 2'b00;
	endproperty
	a_audio_level: assert property (p_audio_level)
		else $error("Audio mode regulator level is not 3.3V.");

	property p_pullups;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (charger_pullup_plus_line == ($past(ctrl_r[4]) || $past(mode_serial)))
			&& (charger_pullup_minus_line == ($past(ctrl_r[5]) || $past(mode_serial)));
	endproperty
	a_pullups: assert property (p_pullups)
		else $error("Pull-up enables disagree with bits and mode.");

	property p_bus_level;
		@(posedge pclk) disable iff (!presetn)
		(phy_mode == uxp_pkg::MODE_BUS) |=> regulated_supply_level == $past(ctrl_r[7:6]);
	endproperty
	a_bus_level: assert property (p_bus_level)
		else $error("Bus mode level does not follow the bus field.");

	property p_answer_next;
		@(posedge pclk) disable iff (!presetn)
		setup_ph |=> pready && (pslverr == !$past(hit_any));
	endproperty
	a_answer_next: assert property (p_answer_next)
		else $error("Setup cycle was not answered in the next cycle.");

	property p_idle_quiet;
		@(posedge pclk) disable iff (!presetn)
		!setup_ph |=> !pready && !pslverr && (prdata == 32'h00000000);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("Bus answer stood longer than one cycle.");

	property p_unmapped_read;
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !hit_any) |=> (prdata == 32'h00000000);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("Unmapped read returned data.");

	property p_write_refused;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && (!pstrb[0] || !hit_any)) |=>
			(ctrl_r == $past(ctrl_r));
	endproperty
	a_write_refused: assert property (p_write_refused)
		else $error("Refused write changed the register.");

endmodule : uxp_io_regulator_ctrl

// ### rtl/uxp_pkg.sv
// Constants and types shared by the I/O and regulator control block.
package uxp_pkg;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_WRITE = 8'h39;
	localparam logic [7:0] IDX_SET = 8'h3A;
	localparam logic [7:0] IDX_CLEAR = 8'h3B;
	localparam int unsigned ADDR_W_MIN = 10;
	localparam logic [9:0] ADDR_WRITE = {IDX_WRITE, 2'b00};
	localparam logic [9:0] ADDR_SET = {IDX_SET, 2'b00};
	localparam logic [9:0] ADDR_CLEAR = {IDX_CLEAR, 2'b00};

	// ------------------------------------------------------------
	// Field positions, reset value and writable mask
	// ------------------------------------------------------------
	localparam int unsigned BIT_SWAP = 1;
	localparam int unsigned LSB_SER_LVL = 2;
	localparam int unsigned BIT_PU_PLUS = 4;
	localparam int unsigned BIT_PU_MINUS = 5;
	localparam int unsigned LSB_BUS_LVL = 6;
	localparam logic [7:0] CTRL_RESET = 8'h04;
	localparam logic [7:0] CTRL_WMASK = 8'hFE;

	// ------------------------------------------------------------
	// Regulator level codes
	// ------------------------------------------------------------
	localparam logic [1:0] LVL_3V3 = 2'b00;
	localparam logic [1:0] LVL_3V0 = 2'b01;
	localparam logic [1:0] LVL_2V75 = 2'b10;
	localparam logic [1:0] LVL_2V5 = 2'b11;

	// ------------------------------------------------------------
	// Operating modes of the transceiver
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_BUS = 2'b00,
		MODE_SERIAL = 2'b01,
		MODE_AUDIO = 2'b10
	} uxp_mode_t;

	localparam int unsigned SYNC_STAGES = 3;

endpackage : uxp_pkg

// ### rtl/uxp_line_route.sv
// Data line routing between the transceiver, the serial port and the pins.
`timescale 1ns/1ps
module uxp_line_route (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic swap_en,
	input wire logic serial_mode,
	input wire logic audio_mode,
	// Transceiver side
	input wire logic xcvr_dp_out,
	input wire logic xcvr_dm_out,
	input wire logic xcvr_dp_oe,
	input wire logic xcvr_dm_oe,
	output logic xcvr_dp_in,
	output logic xcvr_dm_in,
	// Serial side
	input wire logic uart_tx,
	output logic uart_rx,
	// Pins
	input wire logic dp_i,
	input wire logic dm_i,
	output logic dp_o,
	output logic dp_oe,
	output logic dm_o,
	output logic dm_oe
);

	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	logic [1:0] pin_raw;
	logic [1:0] pin_val_r;
	assign pin_raw = {dm_i, dp_i};

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_sync
			logic [uxp_pkg::SYNC_STAGES-1:0] stg_r;
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					stg_r <= '0;
				else
					stg_r <= {stg_r[uxp_pkg::SYNC_STAGES-2:0], pin_raw[g]};
			end
			// A change counts once the second and third stages agree.
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					pin_val_r[g] <= 1'b0;
				else if (stg_r[1] == stg_r[2])
					pin_val_r[g] <= stg_r[2];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Routing selection
	// ------------------------------------------------------------
	wire plus_v = swap_en ? xcvr_dm_out : xcvr_dp_out;
	wire minus_v = swap_en ? xcvr_dp_out : xcvr_dm_out;
	wire plus_e = swap_en ? xcvr_dm_oe : xcvr_dp_oe;
	wire minus_e = swap_en ? xcvr_dp_oe : xcvr_dm_oe;
	// Serial transmit leaves on the minus line unless swapped.
	wire ser_plus_e = swap_en;
	wire ser_minus_e = !swap_en;
	wire dp_o_nxt = serial_mode ? uart_tx : plus_v;
	wire dm_o_nxt = serial_mode ? uart_tx : minus_v;
	wire dp_oe_nxt = !audio_mode && (serial_mode ? ser_plus_e : plus_e);
	wire dm_oe_nxt = !audio_mode && (serial_mode ? ser_minus_e : minus_e);
	wire rx_nxt = swap_en ? pin_val_r[1] : pin_val_r[0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dp_o <= 1'b0;
			dm_o <= 1'b0;
			dp_oe <= 1'b0;
			dm_oe <= 1'b0;
			xcvr_dp_in <= 1'b0;
			xcvr_dm_in <= 1'b0;
			uart_rx <= 1'b1;
		end
		else
		begin
			dp_o <= dp_o_nxt;
			dm_o <= dm_o_nxt;
			dp_oe <= dp_oe_nxt;
			dm_oe <= dm_oe_nxt;
			xcvr_dp_in <= swap_en ? pin_val_r[1] : pin_val_r[0];
			xcvr_dm_in <= swap_en ? pin_val_r[0] : pin_val_r[1];
			uart_rx <= serial_mode ? rx_nxt : 1'b1;
		end
	end

endmodule : uxp_line_route

// ### dv/uxp_pin_model.sv
// Model of the board-side data lines that gives each wire to one driver by priority: block drive, then far-end drive, then pull-up.
`timescale 1ns/1ps
module uxp_pin_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Block drive and pull-ups
	input wire logic dp_o,
	input wire logic dp_oe,
	input wire logic dm_o,
	input wire logic dm_oe,
	input wire logic pu_plus,
	input wire logic pu_minus,
	// Far-end drive
	input wire logic ext_oe,
	input wire logic ext_lvl,
	// Resolved pin levels
	output logic dp_i,
	output logic dm_i
);
	logic dp_last_r, dm_last_r;

	// A floating line without a pull shows the inverse of its last level.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dp_last_r <= 1'b0;
			dm_last_r <= 1'b0;
		end
		else
		begin
			dp_last_r <= dp_i;
			dm_last_r <= dm_i;
		end
	end

	assign dp_i = dp_oe ? dp_o : ext_oe ? ext_lvl : pu_plus ? 1'b1 : ~dp_last_r;
	assign dm_i = dm_oe ? dm_o : ext_oe ? ext_lvl : pu_minus ? 1'b1 : ~dm_last_r;
endmodule : uxp_pin_model

// ### dv/testbench.sv
// Self-checking bench for the I/O and regulator control register block.
`timescale 1ns/1ps
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic [3:0] pstrb;
	logic [1:0] phy_mode, lvl, v;
	logic tde, xdo, xmo, xoe, xdi, xmi, uart_tx, uart_rx, dp_i, dm_i, dp_o, dp_oe, dm_o, dm_oe;
	logic pup, pum, aud, ext_oe;
	int errors, checks;

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	uxp_io_regulator_ctrl #(.ADDR_W(10)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .phy_mode(phy_mode),
		.transmit_drive_enable(tde), .xcvr_dp_out(xdo), .xcvr_dm_out(xmo), .xcvr_dp_oe(xoe),
		.xcvr_dm_oe(xoe), .xcvr_dp_in(xdi), .xcvr_dm_in(xmi), .uart_tx(uart_tx),
		.uart_rx(uart_rx), .dp_i(dp_i), .dm_i(dm_i), .dp_o(dp_o), .dp_oe(dp_oe), .dm_o(dm_o),
		.dm_oe(dm_oe), .regulated_supply_level(lvl), .charger_pullup_plus_line(pup),
		.charger_pullup_minus_line(pum), .audio_path_en(aud));

	uxp_pin_model pins (.pclk(pclk), .presetn(presetn), .dp_o(dp_o), .dp_oe(dp_oe),
		.dm_o(dm_o), .dm_oe(dm_oe), .pu_plus(pup), .pu_minus(pum), .ext_oe(ext_oe),
		.ext_lvl(1'b0), .dp_i(dp_i), .dm_i(dm_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd_data = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			errors++;
	endtask : apb

	task automatic wrc(input logic [9:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk(32'(err), 32'(e));
	endtask : wrc

	task automatic rdc(input logic [9:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk(32'(err), 32'(e));
		chk(rd_data, exp);
	endtask : rdc

	task automatic rall(input logic [31:0] exp);
		rdc(uxp_pkg::ADDR_WRITE, exp, 1'b0);
		rdc(uxp_pkg::ADDR_SET, exp, 1'b0);
		rdc(uxp_pkg::ADDR_CLEAR, exp, 1'b0);
	endtask : rall

	task automatic complete_run;
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	initial
	begin
		repeat (5000) @(posedge pclk);
		errors++;
		complete_run();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, tde, xdo, xmo, xoe, uart_tx, ext_oe} = 10'h0;
		paddr = 10'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
		phy_mode = 2'b00;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rall(32'h04);
		wrc(uxp_pkg::ADDR_WRITE, 32'hFF, 1'b0);
		rall(32'hFE);
		wrc(uxp_pkg::ADDR_CLEAR, 32'hF0, 1'b0);
		rall(32'h0E);
		wrc(uxp_pkg::ADDR_SET, 32'h40, 1'b0);
		rall(32'h4E);
		wrc(10'h0F0, 32'h00, 1'b1);
		rdc(10'h000, 32'h0, 1'b1);
		rall(32'h4E);
		pstrb <= 4'hE;
		wrc(uxp_pkg::ADDR_WRITE, 32'h00, 1'b0);
		pstrb <= 4'hF;
		rdc(uxp_pkg::ADDR_WRITE, 32'h4E, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			v = 2'(i);
			wrc(uxp_pkg::ADDR_WRITE, {24'h0, v, v, ~v, 2'b00}, 1'b0);
			repeat (3) @(posedge pclk);
			chk(32'({lvl, pup, pum}), 32'({v, v[0], v[1]}));
			phy_mode <= 2'b01;
			repeat (3) @(posedge pclk);
			chk(32'({lvl, pup, pum}), 32'({v, 2'b11}));
			tde <= 1'b1;
			repeat (3) @(posedge pclk);
			chk({30'h0, lvl}, {30'h0, ~v});
			phy_mode <= 2'b10;
			tde <= 1'b0;
			repeat (3) @(posedge pclk);
			chk(32'({lvl, dp_oe, dm_oe, aud}), 32'(5'b00001));
			phy_mode <= 2'b00;
		end
		xdo <= 1'b1;
		xoe <= 1'b1;
		wrc(uxp_pkg::ADDR_WRITE, 32'h00, 1'b0);
		repeat (8) @(posedge pclk);
		chk(32'({dp_o, dm_o, xdi, xmi}), 32'(4'b1010));
		wrc(uxp_pkg::ADDR_SET, 32'h02, 1'b0);
		repeat (8) @(posedge pclk);
		chk(32'({dp_o, dm_o, xdi, xmi}), 32'(4'b0110));
		xoe <= 1'b0;
		ext_oe <= 1'b1;
		phy_mode <= 2'b01;
		uart_tx <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(32'({dp_o, dp_oe, uart_rx}), 32'(3'b110));
		wrc(uxp_pkg::ADDR_CLEAR, 32'h02, 1'b0);
		repeat (8) @(posedge pclk);
		chk(32'({dm_o, dm_oe, uart_rx}), 32'(3'b110));
		presetn <= 1'b0;
		phy_mode <= 2'b00;
		repeat (2) @(posedge pclk);
		chk(32'({lvl, pup, pum, uart_rx}), 32'(5'b00001));
		presetn <= 1'b1;
		rall(32'h04);
		complete_run();
	end
endmodule : testbench
